// >>> include/ssv_pkg.sv
package ssv_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_DETECT    = 8'h04;
    localparam logic [7:0] OFF_CONST     = 8'h08;
    localparam logic [7:0] OFF_WDOG      = 8'h0C;
    localparam logic [7:0] OFF_TIRQ0     = 8'h10;
    localparam logic [7:0] OFF_STATUS    = 8'h20;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h24;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h28;
    localparam logic [7:0] OFF_LOG_IDX   = 8'h2C;
    localparam logic [7:0] OFF_LOG_DATA  = 8'h30;
    // reset values and detect delay bounds
    localparam logic [12:0] CTRL_RST     = 13'h0001;
    localparam logic [7:0]  DETECT_RST   = 8'h14;
    localparam logic [7:0]  DETECT_MIN   = 8'h14;
    localparam logic [7:0]  DETECT_MAX   = 8'hC8;
    localparam logic [15:0] CONST_RST    = 16'h0000;
    localparam logic [15:0] WDOG_RST     = 16'h07D0;
    localparam logic [15:0] TIRQ_RST     = 16'h0000;
    // timing: one tick is 100 us
    localparam int CLK_MHZ          = 10;
    localparam int TICK_US          = 100;
    localparam int TICK_CYC         = TICK_US * CLK_MHZ;
    localparam int DETECT_UNIT_MS   = 100;
    localparam int DETECT_UNIT_TICK = DETECT_UNIT_MS * 1000 / TICK_US;
    localparam int LOW_MIN_MS       = 20;
    localparam int LOW_MIN_TICK     = (LOW_MIN_MS * 1000 + TICK_US - 1) / TICK_US;
    localparam int STABLE_S         = 2;
    localparam int STABLE_TICK      = (STABLE_S * 1000000 + TICK_US - 1) / TICK_US;
    // error log
    localparam int LOG_DEPTH        = 20;
    localparam logic [7:0] ERR_WDOG    = 8'h01;
    localparam logic [7:0] ERR_OVERRUN = 8'h02;
    localparam logic [7:0] ERR_SUPPLY  = 8'h03;
    localparam logic [7:0] ERR_COM     = 8'h04;
    // interrupt status bit positions and width
    localparam int IRQ_WDOG    = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_SUPPLY  = 2;
    localparam int IRQ_TMR0    = 3;
    localparam int IRQ_W       = 7;

    typedef struct packed {
        logic [4:0] run_input_sel;
        logic       rsvd;
        logic       supply_err_mode;
        logic       com_err_rec_en;
        logic       card_backup_en;
        logic       const_scan_en;
        logic       input_run_en;
        logic       out_retain;
        logic       clear_en;
    } ssv_ctrl_t;

    typedef enum logic [1:0] {
        ST_STOP = 2'b00,
        ST_SCAN = 2'b01,
        ST_WAIT = 2'b11
    } ssv_state_t;
endpackage

// >>> verilog/ssv_timer.sv
`timescale 1ns/100ps
module ssv_timer
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        tick,
    input  wire logic        enable,
    input  wire logic [15:0] interval,
    output logic             fire
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        fire_d;
    logic        expire;

    assign expire = enable && tick && (interval != 16'h0000) && (cnt_q <= 16'h0001);
    assign fire_d = expire;
    // reload from the interval on every fire
    assign cnt_d  = (!enable || interval == 16'h0000) ? interval :
                    expire ? interval :
                    tick ? (cnt_q - 16'h0001) : cnt_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_q <= ssv_pkg::TIRQ_RST;
            fire  <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            fire  <= fire_d;
        end
    end
endmodule // ssv_timer

// >>> verilog/ssv_supervisor.sv
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Function
// - stop-to-run with clearing enabled pulses clear of non-latched state
// - on run or stop entry, outputs forced off unless retain selected
// - after reset, wait detect delay (20..200 tenths of second) then detect modules
// - run from switch alone, or switch and assigned input when enabled
// - one selectable input point serves as run/stop input
// - constant scan: short scan waits out the minimum cycle time
// - constant scan: long scan starts next scan at once
// - constant scan: scan longer than constant time flags a timeout
// - scan longer than watchdog time raises an error
// - twenty-entry log, newest overwrites oldest
// - card backup: oldest entry copied out before being overwritten
// - communication errors logged only when recording enabled
// - supply low for 20 ms logs an error and sets unstable flag
// - continue mode: halt, resume after 2 seconds stable supply
// - error mode: stop and blink error indicator rapidly
// - four periodic timer interrupts with own intervals
// - interval registers rewritable while running, used from then on
module ssv_supervisor
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP,
    input  wire logic        RUN_SWITCH,
    input  wire logic [31:0] X_IN,
    input  wire logic        SUPPLY_OK,
    input  wire logic        SCAN_DONE,
    input  wire logic        COM_ERR,
    output logic             RUN,
    output logic             SCAN_START,
    output logic             CLEAR_NONLATCHED,
    output logic             OUTPUTS_OFF,
    output logic             IO_DETECT,
    output logic             ERR_LED,
    output logic             SUPPLY_UNSTABLE,
    output logic [3:0]       TIMER_IRQ_EVENT,
    output logic             CARD_WR,
    output logic [7:0]       CARD_DATA,
    output logic             IRQ
);
    // input synchronisers
    logic [33:0] sync1_q;
    logic [33:0] sync2_q;
    logic        sw_s;
    logic [31:0] x_s;
    logic        sup_s;

    always_ff @(posedge CLK)
    begin
        sync1_q <= {RUN_SWITCH, SUPPLY_OK, X_IN};
        sync2_q <= sync1_q;
    end
    assign sw_s  = sync2_q[33];
    assign sup_s = sync2_q[32];
    assign x_s   = sync2_q[31:0];

    // tick prescaler
    logic [9:0] pre_q;
    logic       tick;
    assign tick = (pre_q == 10'(ssv_pkg::TICK_CYC - 1));
    always_ff @(posedge CLK)
    begin
        if (RST)
            pre_q <= 10'h000;
        else
            pre_q <= tick ? 10'h000 : pre_q + 10'h001;
    end

    // registers
    ssv_pkg::ssv_ctrl_t ctrl_q;
    logic [7:0]  detect_q;
    logic [15:0] const_q;
    logic [15:0] wdog_q;
    logic [15:0] tirq_q [4];
    logic [6:0]  istat_q;
    logic [6:0]  imask_q;
    logic [4:0]  log_idx_q;

    // bus address phase
    logic        ap_valid;
    logic        dp_wr_q;
    logic [7:0]  dp_addr_q;
    logic [31:0] rdata_d;
    assign ap_valid  = HSEL && HTRANS[1] && HREADY;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    logic wr_ctrl;
    logic wr_detect;
    logic wr_const;
    logic wr_wdog;
    logic wr_istat;
    logic wr_imask;
    logic wr_lidx;
    logic [7:0] detect_clamp;
    assign wr_ctrl   = dp_wr_q && hit(dp_addr_q, ssv_pkg::OFF_CTRL);
    assign wr_detect = dp_wr_q && hit(dp_addr_q, ssv_pkg::OFF_DETECT);
    assign wr_const  = dp_wr_q && hit(dp_addr_q, ssv_pkg::OFF_CONST);
    assign wr_wdog   = dp_wr_q && hit(dp_addr_q, ssv_pkg::OFF_WDOG);
    assign wr_istat  = dp_wr_q && hit(dp_addr_q, ssv_pkg::OFF_IRQ_STAT);
    assign wr_imask  = dp_wr_q && hit(dp_addr_q, ssv_pkg::OFF_IRQ_MASK);
    assign wr_lidx   = dp_wr_q && hit(dp_addr_q, ssv_pkg::OFF_LOG_IDX);
    // detect delay held within its bounds
    assign detect_clamp = (HWDATA[7:0] < ssv_pkg::DETECT_MIN) ? ssv_pkg::DETECT_MIN :
                          (HWDATA[7:0] > ssv_pkg::DETECT_MAX) ? ssv_pkg::DETECT_MAX :
                          HWDATA[7:0];

    // run/stop source
    logic run_req;
    logic halt;
    assign run_req = ctrl_q.input_run_en ? (sw_s && x_s[ctrl_q.run_input_sel])
                                         : sw_s;

    // scan sequencer
    ssv_pkg::ssv_state_t st_q;
    ssv_pkg::ssv_state_t st_d;
    logic [15:0] scan_t_q;
    logic        wd_hit_q;
    logic        ov_hit_q;
    logic        go;
    logic        short_scan;
    logic        wait_done;
    logic        restart;
    logic        ev_wdog;
    logic        ev_over;
    assign go         = run_req && !halt;
    assign short_scan = ctrl_q.const_scan_en && (scan_t_q < const_q);
    assign wait_done  = scan_t_q >= const_q;
    assign restart    = (st_q == ssv_pkg::ST_STOP && go)
                     || (st_q == ssv_pkg::ST_SCAN && go && SCAN_DONE && !short_scan)
                     || (st_q == ssv_pkg::ST_WAIT && go && wait_done);
    assign ev_wdog    = st_q == ssv_pkg::ST_SCAN && !wd_hit_q && wdog_q != 16'h0000
                     && scan_t_q > wdog_q;
    assign ev_over    = st_q == ssv_pkg::ST_SCAN && !ov_hit_q && ctrl_q.const_scan_en
                     && const_q != 16'h0000 && scan_t_q > const_q;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ssv_pkg::ST_STOP: st_d = go ? ssv_pkg::ST_SCAN : ssv_pkg::ST_STOP;
            ssv_pkg::ST_SCAN:
            begin
                if (!go)
                    st_d = ssv_pkg::ST_STOP;
                else if (SCAN_DONE && short_scan)
                    st_d = ssv_pkg::ST_WAIT;
            end
            ssv_pkg::ST_WAIT:
            begin
                if (!go)
                    st_d = ssv_pkg::ST_STOP;
                else if (wait_done)
                    st_d = ssv_pkg::ST_SCAN;
            end
            default: st_d = ssv_pkg::ST_STOP;
        endcase
    end

    logic run_d;
    assign run_d = st_d != ssv_pkg::ST_STOP;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_q     <= ssv_pkg::ST_STOP;
            scan_t_q <= 16'h0000;
            wd_hit_q <= 1'b0;
            ov_hit_q <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            scan_t_q <= restart ? 16'h0000 :
                        (tick && scan_t_q != 16'hFFFF) ? scan_t_q + 16'h0001 : scan_t_q;
            wd_hit_q <= restart ? 1'b0 : (wd_hit_q || ev_wdog);
            ov_hit_q <= restart ? 1'b0 : (ov_hit_q || ev_over);
        end
    end

    // mode change outputs
    logic entering_run;
    logic entering_stop;
    assign entering_run  = !RUN && run_d;
    assign entering_stop = RUN && !run_d;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            RUN              <= 1'b0;
            SCAN_START       <= 1'b0;
            CLEAR_NONLATCHED <= 1'b0;
            OUTPUTS_OFF      <= 1'b0;
        end
        else
        begin
            RUN              <= run_d;
            SCAN_START       <= restart;
            CLEAR_NONLATCHED <= entering_run && ctrl_q.clear_en;
            OUTPUTS_OFF      <= (entering_run || entering_stop) && !ctrl_q.out_retain;
        end
    end

    // module detection delay
    logic [17:0] det_cnt_q;
    logic        det_done_q;
    logic [17:0] det_lim;
    assign det_lim = 18'(detect_q * ssv_pkg::DETECT_UNIT_TICK);
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            det_cnt_q  <= 18'h0_0000;
            det_done_q <= 1'b0;
            IO_DETECT  <= 1'b0;
        end
        else
        begin
            det_cnt_q  <= (tick && !det_done_q) ? det_cnt_q + 18'h0_0001 : det_cnt_q;
            det_done_q <= det_done_q || det_cnt_q >= det_lim;
            IO_DETECT  <= !det_done_q && det_cnt_q >= det_lim;
        end
    end

    // supply monitor
    logic [7:0]  low_q;
    logic [14:0] stable_q;
    logic        fault_q;
    logic        ev_supply;
    logic [20:0] blink_q;
    assign ev_supply = !sup_s && tick && low_q == 8'(ssv_pkg::LOW_MIN_TICK - 1);
    assign halt      = fault_q || ev_supply;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            low_q           <= 8'h00;
            stable_q        <= 15'h0000;
            fault_q         <= 1'b0;
            SUPPLY_UNSTABLE <= 1'b0;
            blink_q         <= 21'h00_0000;
        end
        else
        begin
            low_q    <= sup_s ? 8'h00 :
                        (tick && low_q != 8'(ssv_pkg::LOW_MIN_TICK)) ? low_q + 8'h01 : low_q;
            stable_q <= (!sup_s || ev_supply) ? 15'h0000 :
                        (tick && stable_q != 15'(ssv_pkg::STABLE_TICK)) ? stable_q + 15'h0001
                                                                         : stable_q;
            SUPPLY_UNSTABLE <= SUPPLY_UNSTABLE || ev_supply;
            if (ev_supply)
                fault_q <= 1'b1;
            else if (!ctrl_q.supply_err_mode && stable_q == 15'(ssv_pkg::STABLE_TICK))
                fault_q <= 1'b0;
            blink_q <= blink_q + 21'h00_0001;
        end
    end
    assign ERR_LED = fault_q && ctrl_q.supply_err_mode && blink_q[19];

    // error log
    logic [7:0] log_mem [ssv_pkg::LOG_DEPTH];
    logic [4:0] wp_q;
    logic [4:0] cnt_q;
    logic       log_we;
    logic [7:0] log_code;
    logic       com_log;
    logic       log_full;
    logic [4:0] rd_pos;
    logic [5:0] rd_sum;
    assign com_log  = COM_ERR && ctrl_q.com_err_rec_en;
    assign log_we   = ev_wdog || ev_over || ev_supply || com_log;
    assign log_code = ev_supply ? ssv_pkg::ERR_SUPPLY :
                      ev_wdog   ? ssv_pkg::ERR_WDOG :
                      ev_over   ? ssv_pkg::ERR_OVERRUN : ssv_pkg::ERR_COM;
    assign log_full = cnt_q == 5'(ssv_pkg::LOG_DEPTH);
    // oldest entry sits at index 0 of the read window
    assign rd_sum   = (log_full ? {1'b0, wp_q} : 6'h00) + {1'b0, log_idx_q};
    assign rd_pos   = (rd_sum >= 6'(ssv_pkg::LOG_DEPTH)) ? 5'(rd_sum - 6'(ssv_pkg::LOG_DEPTH))
                                                        : rd_sum[4:0];
    always_ff @(posedge CLK)
    begin
        if (log_we)
            log_mem[wp_q] <= log_code;
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            wp_q      <= 5'h00;
            cnt_q     <= 5'h00;
            CARD_WR   <= 1'b0;
            CARD_DATA <= 8'h00;
        end
        else
        begin
            if (log_we)
            begin
                wp_q  <= (wp_q == 5'(ssv_pkg::LOG_DEPTH - 1)) ? 5'h00 : wp_q + 5'h01;
                cnt_q <= log_full ? cnt_q : cnt_q + 5'h01;
            end
            CARD_WR <= log_we && log_full && ctrl_q.card_backup_en;
            if (log_we && log_full)
                CARD_DATA <= log_mem[wp_q];
        end
    end

    // periodic timer interrupts
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_tmr
            ssv_timer u_tmr
            (
                .clk      (CLK),
                .rst      (RST),
                .tick     (tick),
                .enable   (RUN),
                .interval (tirq_q[gi]),
                .fire     (TIMER_IRQ_EVENT[gi])
            );
            always_ff @(posedge CLK)
            begin
                if (RST)
                    tirq_q[gi] <= ssv_pkg::TIRQ_RST;
                else if (dp_wr_q && hit(dp_addr_q, ssv_pkg::OFF_TIRQ0 + 8'(4 * gi)))
                    tirq_q[gi] <= HWDATA[15:0];
            end
        end
    endgenerate

    // sticky interrupt status
    logic [6:0] ev_vec;
    assign ev_vec = {TIMER_IRQ_EVENT, ev_supply, ev_over, ev_wdog};
    assign IRQ    = |(istat_q & imask_q);

    // register writes and read data
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ctrl_q    <= ssv_pkg::CTRL_RST;
            detect_q  <= ssv_pkg::DETECT_RST;
            const_q   <= ssv_pkg::CONST_RST;
            wdog_q    <= ssv_pkg::WDOG_RST;
            istat_q   <= 7'h00;
            imask_q   <= 7'h00;
            log_idx_q <= 5'h00;
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 8'h00;
            HRDATA    <= 32'h0000_0000;
        end
        else
        begin
            dp_wr_q   <= ap_valid && HWRITE;
            dp_addr_q <= HADDR[7:0];
            HRDATA    <= (ap_valid && !HWRITE) ? rdata_d : 32'h0000_0000;
            if (wr_ctrl)
                ctrl_q <= HWDATA[12:0];
            if (wr_detect)
                detect_q <= detect_clamp;
            if (wr_const)
                const_q <= HWDATA[15:0];
            if (wr_wdog)
                wdog_q <= HWDATA[15:0];
            if (wr_imask)
                imask_q <= HWDATA[6:0];
            if (wr_lidx)
                log_idx_q <= HWDATA[4:0];
            // set wins over write-one-clear
            istat_q <= (istat_q & ~(wr_istat ? HWDATA[6:0] : 7'h00)) | ev_vec;
        end
    end

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (HADDR[7:0])
            ssv_pkg::OFF_CTRL:     rdata_d = {19'h0_0000, ctrl_q};
            ssv_pkg::OFF_DETECT:   rdata_d = {24'h00_0000, detect_q};
            ssv_pkg::OFF_CONST:    rdata_d = {16'h0000, const_q};
            ssv_pkg::OFF_WDOG:     rdata_d = {16'h0000, wdog_q};
            8'h10:                 rdata_d = {16'h0000, tirq_q[0]};
            8'h14:                 rdata_d = {16'h0000, tirq_q[1]};
            8'h18:                 rdata_d = {16'h0000, tirq_q[2]};
            8'h1C:                 rdata_d = {16'h0000, tirq_q[3]};
            ssv_pkg::OFF_STATUS:   rdata_d = {19'h0_0000, cnt_q, 4'h0, fault_q,
                                              det_done_q, SUPPLY_UNSTABLE, RUN};
            ssv_pkg::OFF_IRQ_STAT: rdata_d = {25'h000_0000, istat_q};
            ssv_pkg::OFF_IRQ_MASK: rdata_d = {25'h000_0000, imask_q};
            ssv_pkg::OFF_LOG_IDX:  rdata_d = {27'h000_0000, log_idx_q};
            ssv_pkg::OFF_LOG_DATA: rdata_d = (log_idx_q < cnt_q) ? {24'h00_0000, log_mem[rd_pos]}
                                                                 : 32'h0000_0000;
            default:               rdata_d = 32'h0000_0000;
        endcase
    end
endmodule // ssv_supervisor

// >>> verif/ssv_supervisor_monitor.sv
`timescale 1ns/100ps
module ssv_supervisor_monitor
(
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic       HREADYOUT,
    input wire logic       HRESP,
    input wire logic       RUN,
    input wire logic       SCAN_START,
    input wire logic       CLEAR_NONLATCHED,
    input wire logic       OUTPUTS_OFF,
    input wire logic       IO_DETECT,
    input wire logic       ERR_LED,
    input wire logic       SUPPLY_UNSTABLE,
    input wire logic [3:0] TIMER_IRQ_EVENT,
    input wire logic       CARD_WR,
    input wire logic [7:0] CARD_DATA
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic [31:0] up_q;
    logic        det_q;
    always_ff @(posedge CLK)
    begin
        up_q  <= RST ? 32'h0000_0000 : up_q + 32'h0000_0001;
        det_q <= !RST && (det_q || IO_DETECT);
    end
    bus_ok_a: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not zero-wait okay");
    clear_a: assert property (CLEAR_NONLATCHED |-> RUN && !$past(RUN))
        else $error("clear outside stop to run");
    outoff_a: assert property (OUTPUTS_OFF |-> RUN != $past(RUN))
        else $error("outputs off without run change");
    detect_a: assert property (IO_DETECT |-> !det_q && up_q >= 32'd19_999_000)
        else $error("module detect early or repeated");
    start_a: assert property (SCAN_START |-> RUN ##1 !SCAN_START)
        else $error("scan start while stopped");
    tmr_run_a: assert property (|TIMER_IRQ_EVENT |-> $past(RUN) || $past(RUN, 2))
        else $error("timer event while stopped");
    tmr_gap_a: assert property (TIMER_IRQ_EVENT[0] |=> !TIMER_IRQ_EVENT[0] [*8])
        else $error("timer event period too short");
    card_wr_a: assert property (
        CARD_WR |-> CARD_DATA inside {8'h01, 8'h02, 8'h03, 8'h04} ##1 !CARD_WR)
        else $error("bad card copy");
    unstable_a: assert property (SUPPLY_UNSTABLE |=> SUPPLY_UNSTABLE)
        else $error("unstable flag dropped");
    led_a: assert property (ERR_LED |-> SUPPLY_UNSTABLE && !RUN)
        else $error("error blink without supply fault");
endmodule // ssv_supervisor_monitor
bind ssv_supervisor ssv_supervisor_monitor u_mon (.*);

// >>> verif/ssv_scan_engine.sv
`timescale 1ns/100ps
module ssv_scan_engine
(
    input  wire logic        clk,
    input  wire logic        start,
    input  wire logic [15:0] dly,
    output logic             done
);
    logic [15:0] cnt_q = 16'h0000;
    logic        busy_q = 1'b0;
    initial done = 1'b0;
    // one finish pulse per scan start, dly cycles later
    always @(posedge clk)
    begin
        done <= 1'b0;
        if (start)
        begin
            busy_q <= 1'b1;
            cnt_q  <= dly;
        end
        else if (busy_q && cnt_q <= 16'h0001)
        begin
            busy_q <= 1'b0;
            done   <= 1'b1;
        end
        else
            cnt_q <= cnt_q - 16'h0001;
    end
endmodule // ssv_scan_engine

// >>> verif/ssv_supervisor_tb_top.sv
`timescale 1ns/100ps
module ssv_supervisor_tb_top;
    logic        CLK = 0, RST = 1, HSEL = 1, HWRITE = 0, RUN_SWITCH = 0;
    logic        SUPPLY_OK = 1, COM_ERR = 0, SCAN_DONE;
    logic [1:0]  HTRANS = 2'h0;
    logic [2:0]  HSIZE = 3'h2;
    logic [31:0] HADDR = 32'h0000_0000, HWDATA = 32'h0000_0000, X_IN = 32'h0000_0000;
    logic [31:0] HRDATA, rv;
    logic [15:0] dly = 16'h0005;
    logic        HREADYOUT, HRESP, RUN, SCAN_START, CLEAR_NONLATCHED, OUTPUTS_OFF, IO_DETECT;
    logic        ERR_LED, SUPPLY_UNSTABLE, CARD_WR, IRQ;
    logic [3:0]  TIMER_IRQ_EVENT;
    logic [7:0]  CARD_DATA, cd;
    int          n_fail = 0, n_compared = 0, cyc = 0, t, n_off, n_clr, ncard, nt[4];

    always #50 CLK = ~CLK;
    ssv_supervisor u_dut (.HREADY(HREADYOUT), .*);
    ssv_scan_engine u_eng (.clk(CLK), .start(SCAN_START), .dly(dly), .done(SCAN_DONE));

    always @(posedge CLK)
    begin
        cyc++;
        if (OUTPUTS_OFF === 1'b1) n_off++;
        if (CLEAR_NONLATCHED === 1'b1) n_clr++;
        if (CARD_WR === 1'b1) begin ncard++; cd = CARD_DATA; end
        for (int k = 0; k < 4; k++) if (TIMER_IRQ_EVENT[k] === 1'b1) nt[k]++;
        if (cyc == 90000) begin n_fail++; stop_test; end
    end

    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic ck(input logic c, input string m);
        n_compared++;
        if (c !== 1'b1) begin n_fail++; $display("Error %0t %s", $time, m); end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        HADDR  <= 32'(a);
        HTRANS <= 2'h2;
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rv = HRDATA;
    endtask

    function automatic logic sg(input int k);
        case (k)
            0: return SCAN_START;
            1: return TIMER_IRQ_EVENT[0];
            2: return SCAN_DONE;
            3: return RUN;
            default: return !RUN;
        endcase
    endfunction

    // cycles until the chosen signal is seen high
    task automatic wt(input int k, input int m);
        t = 0;
        @(posedge CLK);
        while (sg(k) !== 1'b1 && t < m) begin @(posedge CLK); t++; end
        ck(t < m, "wait ran out");
    endtask

    task automatic pc(input int n);
        repeat (n) begin COM_ERR <= 1'b1; @(posedge CLK); COM_ERR <= 1'b0; @(posedge CLK); end
    endtask

    task automatic t_regs;
        bus(ssv_pkg::OFF_CTRL, 0, 0);
        ck(rv === 32'h0000_0001, "ctrl reset");
        bus(ssv_pkg::OFF_DETECT, 0, 0);
        ck(rv === 32'(ssv_pkg::DETECT_RST), "detect reset");
        bus(ssv_pkg::OFF_DETECT, 1, 32'h0000_00FF);
        bus(ssv_pkg::OFF_DETECT, 0, 0);
        ck(rv === 32'(ssv_pkg::DETECT_MAX), "detect clamp");
        bus(8'h40, 0, 0);
        ck(rv === 32'h0000_0000, "unmapped read");
        bus(ssv_pkg::OFF_STATUS, 0, 0);
        ck(rv === 32'h0000_0000, "status after reset");
    endtask

    task automatic t_log;
        pc(3);
        bus(ssv_pkg::OFF_STATUS, 0, 0);
        ck(rv[12:8] === 5'h00, "com error logged while off");
        bus(ssv_pkg::OFF_CTRL, 1, 32'h0000_0031);
        pc(20);
        ck(ncard == 0, "card copy before full");
        pc(1);
        bus(ssv_pkg::OFF_STATUS, 0, 0);
        ck(rv[12:8] === 5'(ssv_pkg::LOG_DEPTH), "log depth");
        ck(ncard == 1 && cd === ssv_pkg::ERR_COM, "card copy");
    endtask

    task automatic t_run;
        bus(ssv_pkg::OFF_CTRL, 1, 32'h0000_0001);
        RUN_SWITCH <= 1'b1;
        wt(3, 50);
        repeat (4) @(posedge CLK);
        ck(n_clr == 1 && n_off == 1, "run entry pulses");
        bus(ssv_pkg::OFF_CTRL, 1, 32'h0000_0506);
        RUN_SWITCH <= 1'b0;
        wt(4, 50);
        RUN_SWITCH <= 1'b1;
        repeat (20) @(posedge CLK);
        ck(RUN === 1'b0 && n_off == 1, "input gate or retain");
        X_IN <= 32'h0000_0020;
        wt(3, 50);
        X_IN <= 32'hFFFF_FFDF;
        wt(4, 50);
        ck(n_clr == 1, "clear while disabled");
        X_IN <= 32'h0000_0020;
        wt(3, 50);
    endtask

    task automatic t_const;
        bus(ssv_pkg::OFF_CONST, 1, 32'h0000_0002);
        bus(ssv_pkg::OFF_CTRL, 1, 32'h0000_000A);
        wt(0, 4000);
        wt(0, 4000);
        ck(t >= 1000 && t <= 3000, "short scan not padded");
        dly <= 16'd3000;
        wt(0, 4000);
        wt(0, 4000);
        wt(2, 4000);
        wt(0, 10);
        ck(t <= 1, "long scan restart late");
        bus(ssv_pkg::OFF_IRQ_STAT, 0, 0);
        ck(rv[ssv_pkg::IRQ_OVERRUN] === 1'b1, "overrun");
    endtask

    task automatic t_wdog;
        bus(ssv_pkg::OFF_WDOG, 1, 32'h0000_0003);
        bus(ssv_pkg::OFF_CTRL, 1, 32'h0000_0002);
        bus(ssv_pkg::OFF_IRQ_MASK, 1, 32'h0000_0000);
        dly <= 16'd5000;
        wt(0, 6000);
        wt(0, 6000);
        wt(2, 6000);
        bus(ssv_pkg::OFF_IRQ_STAT, 0, 0);
        ck(rv[ssv_pkg::IRQ_WDOG] === 1'b1 && IRQ === 1'b0, "watchdog or mask");
        bus(ssv_pkg::OFF_IRQ_MASK, 1, 32'h0000_0001);
        @(posedge CLK);
        ck(IRQ === 1'b1, "irq not raised");
        dly <= 16'd1000;
        wt(0, 6000);
        wt(0, 6000);
        bus(ssv_pkg::OFF_IRQ_STAT, 1, 32'h0000_007F);
        repeat (3) wt(0, 3000);
        ck(IRQ === 1'b0, "watchdog not restarted per scan");
    endtask

    task automatic t_tmr;
        dly <= 16'h0005;
        bus(ssv_pkg::OFF_TIRQ0, 1, 32'h0000_0002);
        wt(1, 3000);
        wt(1, 3000);
        ck(t + 1 == 2 * ssv_pkg::TICK_CYC, "timer period");
        bus(ssv_pkg::OFF_TIRQ0, 1, 32'h0000_0001);
        wt(1, 3000);
        wt(1, 3000);
        ck(t + 1 == ssv_pkg::TICK_CYC, "new period not applied");
        for (int k = 1; k < 4; k++) bus(ssv_pkg::OFF_TIRQ0 + 8'(4 * k), 1, 32'(k));
        nt = '{0, 0, 0, 0};
        repeat (6000) @(posedge CLK);
        for (int k = 1; k < 4; k++) ck(nt[k] >= 6 / k - 1 && nt[k] <= 6 / k, "timer count");
    endtask

    initial
    begin
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        t_regs;
        t_log;
        t_run;
        t_const;
        t_wdog;
        t_tmr;
        stop_test;
    end
endmodule // ssv_supervisor_tb_top
